//--- hdl/qei_defines.vh
// Constants for the quadrature encoder block: offsets, fields, resets.
// Assumes a 32-bit AHB-Lite register window with byte addressing.
`ifndef QEI_DEFINES_VH
`define QEI_DEFINES_VH

// Register byte offsets
`define QEI_CTRL_OFS 8'h00
`define QEI_STAT_OFS 8'h04
`define QEI_POS_OFS 8'h08
`define QEI_MAXPOS_OFS 8'h0c
`define QEI_VPERIOD_OFS 8'h10
`define QEI_VTIMER_OFS 8'h14
`define QEI_VRUN_OFS 8'h18
`define QEI_VSPEED_OFS 8'h1c
`define QEI_INTSTAT_OFS 8'h20
`define QEI_INTMASK_OFS 8'h24
`define QEI_INTMSKD_OFS 8'h28

// Control fields
`define QEI_CTRL_ENABLE 0
`define QEI_CTRL_SWAP 1
`define QEI_CTRL_IDXRST 2
`define QEI_CTRL_STEPDIR 3
`define QEI_CTRL_BOTH 4
`define QEI_CTRL_VEL_EN 5
`define QEI_CTRL_PDIV_LO 6
`define QEI_CTRL_PDIV_HI 8
`define QEI_CTRL_W 9

// Status fields
`define QEI_STAT_ERROR 0
`define QEI_STAT_DIR 1

// Event bits
`define QEI_EV_INDEX 0
`define QEI_EV_TIMER 1
`define QEI_EV_DIR 2
`define QEI_EV_ERROR 3
`define QEI_EV_W 4

// Reset values
`define QEI_CTRL_RST 9'h000
`define QEI_MAXPOS_RST 32'hffffffff
`define QEI_VPERIOD_RST 32'h0000ffff

`endif

//--- hdl/qei_edge_decoder.v
// Edge decoder for two encoder channels and an index input.
// Assumes inputs already synchronous to clock_in; channels arrive swapped as set.
`timescale 1ns/10ps
`default_nettype none

module qei_edge_decoder (
    input wire clock_in,
    input wire rstn_in,
    input wire enable_in,
    input wire chan_a_in,
    input wire chan_b_in,
    input wire index_in,
    input wire step_direction_mode_select_in,
    input wire both_channel_count_select_in,
    output reg count_pulse_out,
    output reg dir_fwd_out,
    output reg dir_change_out,
    output reg phase_error_out,
    output reg index_pulse_out
);

reg a_q;
reg b_q;
reg idx_q;
reg a_chg;
reg b_chg;
reg cnt_d;
reg fwd_d;
reg err_d;

always @* begin
    a_chg = chan_a_in ^ a_q;
    b_chg = chan_b_in ^ b_q;
    cnt_d = 1'b0;
    fwd_d = dir_fwd_out;
    err_d = 1'b0;
    if (step_direction_mode_select_in) begin
        if (chan_a_in && !a_q) begin
            cnt_d = 1'b1;
            fwd_d = chan_b_in;
        end
    end else if (a_chg && b_chg) begin
        err_d = 1'b1;
    end else if (a_chg) begin
        cnt_d = 1'b1;
        fwd_d = chan_a_in ^ chan_b_in;
    end else if (b_chg) begin
        cnt_d = both_channel_count_select_in;
        fwd_d = ~(chan_a_in ^ chan_b_in);
    end
end

always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        a_q <= 1'b0;
        b_q <= 1'b0;
        idx_q <= 1'b0;
        count_pulse_out <= 1'b0;
        dir_fwd_out <= 1'b1;
        dir_change_out <= 1'b0;
        phase_error_out <= 1'b0;
        index_pulse_out <= 1'b0;
    end else begin
        a_q <= chan_a_in;
        b_q <= chan_b_in;
        idx_q <= index_in;
        count_pulse_out <= enable_in & cnt_d;
        phase_error_out <= enable_in & err_d;
        index_pulse_out <= enable_in & index_in & ~idx_q;
        dir_change_out <= enable_in & cnt_d & (fwd_d != dir_fwd_out);
        if (enable_in && cnt_d) begin
            dir_fwd_out <= fwd_d;
        end
    end
end

endmodule // qei_edge_decoder

`default_nettype wire

//--- hdl/qei_position_velocity.v
// Quadrature encoder position and velocity unit with AHB-Lite registers.
// Assumes encoder pins synchronous to clock_in and a single AHB-Lite master.
`timescale 1ns/10ps
`include "qei_defines.vh"
`default_nettype none

module qei_position_velocity #(
    parameter POS_W = 32,
    parameter VEL_W = 32,
    parameter ADDR_W = 8
) (
    input wire clock_in,
    input wire rstn_in,
    input wire hsel_in,
    input wire [ADDR_W-1:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire hready_in,
    input wire [31:0] hwdata_in,
    output reg [31:0] hrdata_out,
    output reg hreadyout_out,
    output reg hresp_out,
    input wire chan_a_in,
    input wire chan_b_in,
    input wire index_in,
    output reg irq_out,
    output reg direction_out
);

// Control and software state
reg [`QEI_CTRL_W-1:0] ctrl_q;
reg [POS_W-1:0] position_q;
reg [POS_W-1:0] max_position_value_q;
reg [VEL_W-1:0] velocity_timer_period_q;
reg [VEL_W-1:0] vel_timer_q;
reg [VEL_W-1:0] vel_running_q;
reg [VEL_W-1:0] vel_speed_q;
reg [7:0] prediv_cnt_q;
reg error_seen_q;
wire [`QEI_EV_W-1:0] int_status_q;
reg [`QEI_EV_W-1:0] int_mask_q;
reg [POS_W-1:0] position_d;
reg [31:0] rdata_d;

// Bus states
localparam BUS_IDLE = 2'b00;
localparam BUS_WRITE = 2'b01;
localparam BUS_READ = 2'b10;
reg [1:0] bus_state_q;
reg [1:0] bus_state_d;
reg [ADDR_W-1:0] addr_q;

wire enable = ctrl_q[`QEI_CTRL_ENABLE];
wire channel_swap_select = ctrl_q[`QEI_CTRL_SWAP];
wire index_reset_select = ctrl_q[`QEI_CTRL_IDXRST];
wire step_direction_mode_select = ctrl_q[`QEI_CTRL_STEPDIR];
wire both_channel_count_select = ctrl_q[`QEI_CTRL_BOTH];
wire vel_enable = ctrl_q[`QEI_CTRL_VEL_EN];
wire [2:0] velocity_predivider = ctrl_q[`QEI_CTRL_PDIV_HI:`QEI_CTRL_PDIV_LO];

wire chan_first = channel_swap_select ? chan_b_in : chan_a_in;
wire chan_second = channel_swap_select ? chan_a_in : chan_b_in;

wire count_pulse;
wire dir_fwd;
wire direction_change_event;
wire phase_error_event;
wire index_detect_event;

qei_edge_decoder u_decoder (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .enable_in(enable),
    .chan_a_in(chan_first),
    .chan_b_in(chan_second),
    .index_in(index_in),
    .step_direction_mode_select_in(step_direction_mode_select),
    .both_channel_count_select_in(both_channel_count_select),
    .count_pulse_out(count_pulse),
    .dir_fwd_out(dir_fwd),
    .dir_change_out(direction_change_event),
    .phase_error_out(phase_error_event),
    .index_pulse_out(index_detect_event)
);

// Bus decode
wire bus_take = hsel_in & htrans_in[1] & hready_in;
wire rd_pend = (bus_state_q == BUS_READ);
wire wr_now = (bus_state_q == BUS_WRITE);
wire [31:0] wdata = hwdata_in;

wire wr_ctrl = wr_now && (addr_q == `QEI_CTRL_OFS);
wire wr_pos = wr_now && (addr_q == `QEI_POS_OFS);
wire wr_max = wr_now && (addr_q == `QEI_MAXPOS_OFS);
wire wr_per = wr_now && (addr_q == `QEI_VPERIOD_OFS);
wire wr_stat = wr_now && (addr_q == `QEI_STAT_OFS);
wire wr_iclr = wr_now && (addr_q == `QEI_INTSTAT_OFS);
wire wr_mask = wr_now && (addr_q == `QEI_INTMASK_OFS);

// Velocity timing
wire vel_active = enable & vel_enable;
wire [7:0] prediv_top = (8'h01 << velocity_predivider) - 8'h01;
wire prediv_tick = count_pulse && (prediv_cnt_q == prediv_top);
wire timer_expire = vel_active && (vel_timer_q == {VEL_W{1'b0}});
wire [VEL_W-1:0] run_inc = prediv_tick ? {{(VEL_W-1){1'b0}}, 1'b1} : {VEL_W{1'b0}};

// Event collection
wire [`QEI_EV_W-1:0] events;
assign events[`QEI_EV_INDEX] = index_detect_event;
assign events[`QEI_EV_TIMER] = timer_expire;
assign events[`QEI_EV_DIR] = direction_change_event;
assign events[`QEI_EV_ERROR] = phase_error_event;

wire [`QEI_EV_W-1:0] masked_status = int_status_q & int_mask_q;

// Bus next state
always @* begin
    bus_state_d = BUS_IDLE;
    case (bus_state_q)
        BUS_IDLE, BUS_WRITE: begin
            if (bus_take) begin
                bus_state_d = hwrite_in ? BUS_WRITE : BUS_READ;
            end
        end
        BUS_READ: begin
            // Wait state ends, nothing taken
            bus_state_d = BUS_IDLE;
        end
        default: begin
            bus_state_d = BUS_IDLE;
        end
    endcase
end

// Bus handshake
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        bus_state_q <= BUS_IDLE;
        addr_q <= {ADDR_W{1'b0}};
        hreadyout_out <= 1'b1;
        hresp_out <= 1'b0;
    end else begin
        bus_state_q <= bus_state_d;
        hresp_out <= 1'b0;
        hreadyout_out <= (bus_state_d != BUS_READ);
        if (bus_take && !rd_pend) begin
            addr_q <= {haddr_in[ADDR_W-1:2], 2'b00};
        end
    end
end

// Read data select
always @* begin
    rdata_d = 32'h00000000;
    case (addr_q)
        `QEI_CTRL_OFS: rdata_d = {{(32-`QEI_CTRL_W){1'b0}}, ctrl_q};
        `QEI_STAT_OFS: rdata_d = {30'h00000000, dir_fwd, error_seen_q};
        `QEI_POS_OFS: rdata_d = position_q;
        `QEI_MAXPOS_OFS: rdata_d = max_position_value_q;
        `QEI_VPERIOD_OFS: rdata_d = velocity_timer_period_q;
        `QEI_VTIMER_OFS: rdata_d = vel_timer_q;
        `QEI_VRUN_OFS: rdata_d = vel_running_q;
        `QEI_VSPEED_OFS: rdata_d = vel_speed_q;
        `QEI_INTSTAT_OFS: rdata_d = {28'h0000000, int_status_q};
        `QEI_INTMASK_OFS: rdata_d = {28'h0000000, int_mask_q};
        `QEI_INTMSKD_OFS: rdata_d = {28'h0000000, masked_status};
        default: rdata_d = 32'h00000000;
    endcase
end

// Read data, one wait state
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        hrdata_out <= 32'h00000000;
    end else if (rd_pend) begin
        hrdata_out <= rdata_d;
    end
end

// Configuration registers
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        ctrl_q <= `QEI_CTRL_RST;
        max_position_value_q <= `QEI_MAXPOS_RST;
        velocity_timer_period_q <= `QEI_VPERIOD_RST;
        int_mask_q <= {`QEI_EV_W{1'b0}};
    end else begin
        if (wr_ctrl) begin
            ctrl_q <= wdata[`QEI_CTRL_W-1:0];
        end
        if (wr_max) begin
            max_position_value_q <= wdata[POS_W-1:0];
        end
        if (wr_per) begin
            velocity_timer_period_q <= wdata[VEL_W-1:0];
        end
        if (wr_mask) begin
            int_mask_q <= wdata[`QEI_EV_W-1:0];
        end
    end
end

// Position next value
always @* begin
    position_d = position_q;
    if (wr_pos) begin
        position_d = wdata[POS_W-1:0];
    end else if (enable) begin
        if (index_detect_event && index_reset_select) begin
            position_d = dir_fwd ? {POS_W{1'b0}} : max_position_value_q;
        end else if (count_pulse) begin
            if (dir_fwd) begin
                position_d = (position_q >= max_position_value_q) ?
                    {POS_W{1'b0}} : position_q + {{(POS_W-1){1'b0}}, 1'b1};
            end else begin
                position_d = (position_q == {POS_W{1'b0}}) ?
                    max_position_value_q : position_q - {{(POS_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

// Position integrator
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        position_q <= {POS_W{1'b0}};
    end else begin
        position_q <= position_d;
    end
end

always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        prediv_cnt_q <= 8'h00;
    end else if (!vel_active) begin
        prediv_cnt_q <= 8'h00;
    end else if (count_pulse) begin
        prediv_cnt_q <= prediv_tick ? 8'h00 : prediv_cnt_q + 8'h01;
    end
end

// Velocity accumulator
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        vel_timer_q <= {VEL_W{1'b0}};
        vel_running_q <= {VEL_W{1'b0}};
        vel_speed_q <= {VEL_W{1'b0}};
    end else if (!vel_active) begin
        vel_timer_q <= velocity_timer_period_q;
        vel_running_q <= {VEL_W{1'b0}};
    end else begin
        if (timer_expire) begin
            vel_timer_q <= velocity_timer_period_q;
            vel_speed_q <= vel_running_q + run_inc;
            vel_running_q <= {VEL_W{1'b0}};
        end else begin
            vel_timer_q <= vel_timer_q - {{(VEL_W-1){1'b0}}, 1'b1};
            vel_running_q <= vel_running_q + run_inc;
        end
    end
end

always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        error_seen_q <= 1'b0;
    end else if (phase_error_event) begin
        error_seen_q <= 1'b1;
    end else if (wr_stat && wdata[`QEI_STAT_ERROR]) begin
        error_seen_q <= 1'b0;
    end
end

genvar ev_i;
generate
    for (ev_i = 0; ev_i < `QEI_EV_W; ev_i = ev_i + 1) begin : g_event
        reg flag_q;
        always @(posedge clock_in or negedge rstn_in) begin
            if (!rstn_in) begin
                flag_q <= 1'b0;
            end else if (events[ev_i]) begin
                flag_q <= 1'b1;
            end else if (wr_iclr && wdata[ev_i]) begin
                flag_q <= 1'b0;
            end
        end
        assign int_status_q[ev_i] = flag_q;
    end
endgenerate

// Interrupt and direction outputs
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        irq_out <= 1'b0;
        direction_out <= 1'b1;
    end else begin
        irq_out <= |masked_status;
        direction_out <= dir_fwd;
    end
end

endmodule // qei_position_velocity

`default_nettype wire

//--- dv/qei_props.sv
// Checker of bus timing, interrupt and direction at the ports.
// Assumes hready_in is tied to hreadyout_out.
`timescale 1ns/10ps
`default_nettype none
module qei_props #(parameter ADDR_W = 8) (
    input wire clock_in,
    input wire rstn_in,
    input wire hsel_in,
    input wire [ADDR_W-1:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire hready_in,
    input wire [31:0] hwdata_in,
    input wire [31:0] hrdata_out,
    input wire hreadyout_out,
    input wire hresp_out,
    input wire chan_a_in,
    input wire chan_b_in,
    input wire index_in,
    input wire irq_out,
    input wire direction_out
);
    logic rd_t, wr_t, a_q, b_q;
    logic [4:0] rd_q, wr_q, mv_q;
    assign rd_t = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
    assign wr_t = hsel_in & htrans_in[1] & hready_in & hwrite_in;
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_q <= 5'h00;
            wr_q <= 5'h00;
            mv_q <= 5'h00;
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            rd_q <= {rd_q[3:0], rd_t};
            wr_q <= {wr_q[3:0], wr_t};
            mv_q <= {mv_q[3:0], (chan_a_in ^ a_q) | (chan_b_in ^ b_q)};
            a_q <= chan_a_in;
            b_q <= chan_b_in;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    resp_okay_a:
    assert property (hresp_out == 1'b0) else $error("Bad response");
    read_wait_a:
    assert property (rd_t |=> !hreadyout_out ##1 hreadyout_out) else $error("Read wait");
    write_nowait_a:
    assert property (wr_t |=> hreadyout_out[*2]) else $error("Write wait");
    ready_low_a:
    assert property (!hreadyout_out |-> $past(rd_t)) else $error("Stray wait");
    rdata_hold_a:
    assert property ($changed(hrdata_out) |-> rd_q[1]) else $error("Read data moved");
    dir_cause_a:
    assert property ($changed(direction_out) |-> mv_q != 5'h00) else $error("Direction moved");
    irq_fall_a:
    assert property ($fell(irq_out) |-> wr_q[2]) else $error("Interrupt dropped");
    reset_out_a:
    assert property ($rose(rstn_in) |-> direction_out && !irq_out) else $error("Reset outputs");
    cover property (rd_t);
    cover property ($rose(irq_out));
    cover property ($fell(direction_out));
endmodule // qei_props
bind qei_position_velocity qei_props #(.ADDR_W(ADDR_W)) props_i (
    .clock_in(clock_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hready_in(hready_in), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .chan_a_in(chan_a_in),
    .chan_b_in(chan_b_in), .index_in(index_in), .irq_out(irq_out),
    .direction_out(direction_out));
`default_nettype wire

//--- dv/encoder_model.sv
// Encoder model: quadrature or step/direction waves and an index pulse.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module encoder_model (
    input wire logic clock_in,
    output logic chan_a_out,
    output logic chan_b_out,
    output logic index_out
);
    logic [1:0] ph = 2'h0;
    initial begin
        chan_a_out = 1'b0;
        chan_b_out = 1'b0;
        index_out = 1'b0;
    end
    task automatic set_ab(input logic a, input logic b);
        chan_a_out <= a;
        chan_b_out <= b;
        repeat (6) @(posedge clock_in);
    endtask
    task automatic step(input logic fwd);
        ph = fwd ? ph + 2'h1 : ph - 2'h1;
        set_ab(ph[1] ^ ph[0], ph[1]);
    endtask
    task automatic glitch;
        ph = ph + 2'h2;
        set_ab(ph[1] ^ ph[0], ph[1]);
    endtask
    task automatic clk_step(input logic fwd);
        set_ab(1'b0, fwd);
        set_ab(1'b1, fwd);
    endtask
    task automatic pulse;
        index_out <= 1'b1;
        @(posedge clock_in);
        index_out <= 1'b0;
        repeat (6) @(posedge clock_in);
    endtask
endmodule // encoder_model
`default_nettype wire

//--- dv/quadrature_encoder_position_velocity_tb.sv
// Bench: AHB-Lite master tasks and encoder model, checking register reads.
// Assumes a single master and one clock.
`timescale 1ns/10ps
`default_nettype none
`include "qei_defines.vh"
module quadrature_encoder_position_velocity_tb;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hready, hresp, irq, dir, cha, chb, idx;
    int failures = 0;
    int compares = 0;
    int n;
    always #2 clock_in = ~clock_in;
    encoder_model enc (.clock_in(clock_in), .chan_a_out(cha), .chan_b_out(chb), .index_out(idx));
    qei_position_velocity uut (.clock_in(clock_in), .rstn_in(rstn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .chan_a_in(cha), .chan_b_in(chb), .index_in(idx),
        .irq_out(irq), .direction_out(dir));
    task automatic tally_and_finish;
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge clock_in);
        while (hready !== 1'b1 && k < 20) begin
            @(posedge clock_in);
            k++;
        end
        if (hready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error item %h expected %h seen %h", a, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(a, e, q);
    endtask
    task automatic fin(input int t);
        $display("Test %0d done", t);
    endtask
    initial begin
        repeat (6) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        rd(`QEI_CTRL_OFS, 32'h0);
        rd(`QEI_MAXPOS_OFS, 32'hffffffff);
        rd(`QEI_VPERIOD_OFS, 32'h0000ffff);
        rd(`QEI_STAT_OFS, 32'h2);
        rd(8'h2c, 32'h0);
        fin(1);
        xfer(1'b1, `QEI_MAXPOS_OFS, 32'h5);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h11);
        repeat (3) enc.step(1'b1);
        rd(`QEI_POS_OFS, 32'h3);
        repeat (4) enc.step(1'b0);
        rd(`QEI_POS_OFS, 32'h5);
        rd(`QEI_STAT_OFS, 32'h0);
        rd(`QEI_INTSTAT_OFS, 32'h4);
        fin(2);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h1);
        xfer(1'b1, `QEI_POS_OFS, 32'h0);
        repeat (5) enc.step(1'b1);
        rd(`QEI_POS_OFS, 32'h2);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h3);
        repeat (4) enc.step(1'b1);
        rd(`QEI_POS_OFS, 32'h0);
        rd(`QEI_STAT_OFS, 32'h0);
        fin(3);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h5);
        enc.pulse();
        rd(`QEI_POS_OFS, 32'h5);
        xfer(1'b1, `QEI_POS_OFS, 32'h3);
        enc.step(1'b1);
        enc.pulse();
        rd(`QEI_POS_OFS, 32'h0);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h1);
        xfer(1'b1, `QEI_POS_OFS, 32'h3);
        enc.pulse();
        rd(`QEI_POS_OFS, 32'h3);
        rd(`QEI_INTSTAT_OFS, 32'h5);
        fin(4);
        xfer(1'b1, `QEI_INTSTAT_OFS, 32'hf);
        rd(`QEI_INTSTAT_OFS, 32'h0);
        enc.glitch();
        rd(`QEI_STAT_OFS, 32'h3);
        rd(`QEI_INTSTAT_OFS, 32'h8);
        chk(8'h00, 32'h0, {31'h0, irq});
        xfer(1'b1, `QEI_INTMASK_OFS, 32'h8);
        rd(`QEI_INTMSKD_OFS, 32'h8);
        chk(8'h00, 32'h1, {31'h0, irq});
        xfer(1'b1, `QEI_INTSTAT_OFS, 32'h8);
        xfer(1'b1, `QEI_STAT_OFS, 32'h1);
        rd(`QEI_STAT_OFS, 32'h2);
        chk(8'h00, 32'h0, {31'h0, irq});
        fin(5);
        xfer(1'b1, `QEI_VPERIOD_OFS, 32'h3e7);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h20);
        rd(`QEI_VTIMER_OFS, 32'h3e7);
        rd(`QEI_VRUN_OFS, 32'h0);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h71);
        repeat (4) enc.step(1'b1);
        rd(`QEI_VRUN_OFS, 32'h2);
        n = 0;
        q = 32'h0;
        while (q[1] !== 1'b1 && n < 400) begin
            xfer(1'b0, `QEI_INTSTAT_OFS, 32'h0);
            n++;
        end
        chk(`QEI_INTSTAT_OFS, 32'h2, {30'h0, q[1], 1'b0});
        if (q[1] !== 1'b1) tally_and_finish();
        rd(`QEI_VSPEED_OFS, 32'h2);
        rd(`QEI_VRUN_OFS, 32'h0);
        fin(6);
        xfer(1'b1, `QEI_CTRL_OFS, 32'h9);
        xfer(1'b1, `QEI_POS_OFS, 32'h0);
        repeat (3) enc.clk_step(1'b1);
        rd(`QEI_POS_OFS, 32'h3);
        enc.clk_step(1'b0);
        rd(`QEI_POS_OFS, 32'h2);
        chk(8'h00, 32'h0, {31'h0, dir});
        fin(7);
        tally_and_finish();
    end
endmodule // quadrature_encoder_position_velocity_tb
`default_nettype wire
